//--- hfcd_regs.vh
/*
  Constants for the half-precision decoder and its register map.
  Assumes inclusion by bare name from the design files.
*/
`ifndef HFCD_REGS_VH
`define HFCD_REGS_VH
`define HFCD_ADDR_FP_FLAGS 12'h001
`define HFCD_ADDR_FP_ROUND 12'h002
`define HFCD_ADDR_FP_COMBINED 12'h003
`define HFCD_ADDR_CYCLE 12'hC00
`define HFCD_ADDR_TIME 12'hC01
`define HFCD_ADDR_RETIRED_LOW 12'hC02
`define HFCD_ADDR_CYCLE_HIGH 12'hC80
`define HFCD_ADDR_TIME_HIGH 12'hC81
`define HFCD_ADDR_RETIRED_HIGH 12'hC82
`define HFCD_FLAGS_RESET 5'h00
`define HFCD_ROUND_RESET 3'h0
`define HFCD_ROUND_DYNAMIC 3'h7
`define HFCD_OP_LOAD 7'h07
`define HFCD_OP_STORE 7'h27
`define HFCD_OP_MADD 7'h43
`define HFCD_OP_MSUB 7'h47
`define HFCD_OP_NMSUB 7'h4B
`define HFCD_OP_NMADD 7'h4F
`define HFCD_OP_FP 7'h53
`define HFCD_OP_SYSTEM 7'h73
`define HFCD_WIDTH_HALF 3'h1
`define HFCD_FMT_HALF 2'h2
`define HFCD_F7_ADD 7'h02
`define HFCD_F7_SUB 7'h06
`define HFCD_F7_MUL 7'h0A
`define HFCD_F7_DIV 7'h0E
`define HFCD_F7_SQRT 7'h2E
`define HFCD_F7_SGNJ 7'h12
`define HFCD_F7_MINMAX 7'h16
`define HFCD_F7_TO_S 7'h20
`define HFCD_F7_TO_D 7'h21
`define HFCD_F7_TO_Q 7'h23
`define HFCD_F7_FROM_OTHER 7'h22
`define HFCD_F7_CMP 7'h52
`define HFCD_F7_CLASS_MVX 7'h72
`define HFCD_F7_TO_INT 7'h62
`define HFCD_F7_FROM_INT 7'h6A
`define HFCD_F7_MV_FROM_X 7'h7A
`define HFCD_F12_WAIT_NO_TIMEOUT 12'h00D
`define HFCD_F12_WAIT_SHORT_TIMEOUT 12'h01D
`define HFCD_CLS_NONE 4'h0
`define HFCD_CLS_LOAD 4'h1
`define HFCD_CLS_STORE 4'h2
`define HFCD_CLS_FMA 4'h3
`define HFCD_CLS_ARITH 4'h4
`define HFCD_CLS_SGNJ 4'h5
`define HFCD_CLS_MINMAX 4'h6
`define HFCD_CLS_CMP 4'h7
`define HFCD_CLS_CLASS 4'h8
`define HFCD_CLS_MOVE 4'h9
`define HFCD_CLS_CVT 4'hA
`define HFCD_CLS_WAIT_NO_TIMEOUT 4'hB
`define HFCD_CLS_WAIT_SHORT_TIMEOUT 4'hC
`endif

//--- hfcd_counter64.v
/*
  A 64-bit counter with a count enable, shared by the cycle,
  time and retired-instruction counts. Assumes one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module hfcd_counter64 (
  input wire clk_sys,
  input wire reset_n,
  input wire countEn,
  output reg [63:0] count
);
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      count <= 64'h0000000000000000;
    end else if (countEn) begin
      count <= count + 64'h0000000000000001;
    end
  end
endmodule // hfcd_counter64
`default_nettype wire

//--- hfcd_half_float_csr_decoder.v
/*
  Half-precision and wait-on-reservation decoder with the unprivileged
  register map. Assumes the fetch stage presents one instruction per
  instrValid cycle and the hart supplies retire and timer tick pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hfcd_regs.vh"
// How it works
// - Only allocated register numbers resolve
// - Only counter, timer, float registers exist
// - 0x001 holds read-write accrued flags
// - 0x002 holds rounding mode; dynamic uses it
// - 0x003 combines mode and flags, both written
// - 0xC00 read-only cycle count
// - 0xC01 read-only timer value
// - 0xC02 read-only retired count
// - 0xC80-0xC82 upper halves, 32-bit only
// - Long conversions only on 64-bit base
module hfcd_half_float_csr_decoder (
  input wire clk_sys,
  input wire reset_n,
  input wire is64Bit,
  input wire instrValid,
  input wire [31:0] instr,
  output reg decodeValid,
  output reg [3:0] opClass,
  output reg [6:0] opFunct7,
  output reg [2:0] opMinor,
  output reg opUnsigned,
  output reg opIllegal,
  output reg [2:0] effRoundMode,
  input wire csrRead,
  input wire csrWrite,
  input wire [11:0] csrAddr,
  input wire [31:0] csrWdata,
  output reg [31:0] csrRdata,
  output reg csrError,
  input wire fpFlagsSet,
  input wire [4:0] fpFlagsIn,
  input wire retirePulse,
  input wire timeTick
);
  wire [6:0] opcode = instr[6:0];
  wire [4:0] rd = instr[11:7];
  wire [2:0] funct3 = instr[14:12];
  wire [4:0] rs1 = instr[19:15];
  wire [4:0] rs2 = instr[24:20];
  wire [6:0] funct7 = instr[31:25];
  wire [11:0] funct12 = instr[31:20];
  reg [4:0] fpFlags;
  reg [2:0] roundMode;
  wire [63:0] cycleCount;
  wire [63:0] timeCount;
  wire [63:0] retiredCount;
  reg [3:0] next_class;
  reg next_illegal;
  reg [31:0] next_rdata;
  reg next_error;
  reg roundFieldUsed;

  hfcd_counter64 uCycle (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .countEn(1'b1),
    .count(cycleCount)
  );
  hfcd_counter64 uTime (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .countEn(timeTick),
    .count(timeCount)
  );
  hfcd_counter64 uRetired (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .countEn(retirePulse),
    .count(retiredCount)
  );

  always @* begin
    next_class = `HFCD_CLS_NONE;
    roundFieldUsed = 1'b0;
    case (opcode)
      `HFCD_OP_LOAD: begin
        if (funct3 == `HFCD_WIDTH_HALF) next_class = `HFCD_CLS_LOAD;
      end
      `HFCD_OP_STORE: begin
        if (funct3 == `HFCD_WIDTH_HALF) next_class = `HFCD_CLS_STORE;
      end
      `HFCD_OP_MADD, `HFCD_OP_MSUB, `HFCD_OP_NMSUB, `HFCD_OP_NMADD: begin
        if (instr[26:25] == `HFCD_FMT_HALF) begin
          next_class = `HFCD_CLS_FMA;
          roundFieldUsed = 1'b1;
        end
      end
      `HFCD_OP_FP: begin
        case (funct7)
          `HFCD_F7_ADD, `HFCD_F7_SUB, `HFCD_F7_MUL, `HFCD_F7_DIV: begin
            next_class = `HFCD_CLS_ARITH;
            roundFieldUsed = 1'b1;
          end
          `HFCD_F7_SQRT: begin
            if (rs2 == 5'h00) begin
              next_class = `HFCD_CLS_ARITH;
              roundFieldUsed = 1'b1;
            end
          end
          `HFCD_F7_SGNJ: begin
            if (funct3 <= 3'h2) next_class = `HFCD_CLS_SGNJ;
          end
          `HFCD_F7_MINMAX: begin
            if (funct3 <= 3'h1) next_class = `HFCD_CLS_MINMAX;
          end
          `HFCD_F7_CMP: begin
            if (funct3 <= 3'h2) next_class = `HFCD_CLS_CMP;
          end
          `HFCD_F7_CLASS_MVX: begin
            if (rs2 == 5'h00 && funct3 == 3'h1) next_class = `HFCD_CLS_CLASS;
            else if (rs2 == 5'h00 && funct3 == 3'h0) next_class = `HFCD_CLS_MOVE;
          end
          `HFCD_F7_MV_FROM_X: begin
            if (rs2 == 5'h00 && funct3 == 3'h0) next_class = `HFCD_CLS_MOVE;
          end
          `HFCD_F7_TO_S, `HFCD_F7_TO_D, `HFCD_F7_TO_Q: begin
            if (rs2 == 5'h02) begin
              next_class = `HFCD_CLS_CVT;
              roundFieldUsed = 1'b1;
            end
          end
          `HFCD_F7_FROM_OTHER: begin
            if (rs2 == 5'h00 || rs2 == 5'h01 || rs2 == 5'h03) begin
              next_class = `HFCD_CLS_CVT;
              roundFieldUsed = 1'b1;
            end
          end
          `HFCD_F7_TO_INT, `HFCD_F7_FROM_INT: begin
            // Word forms always; long forms only with a 64-bit base
            if (rs2[4:1] == 4'h0 || (is64Bit && rs2[4:1] == 4'h1)) begin
              next_class = `HFCD_CLS_CVT;
              roundFieldUsed = 1'b1;
            end
          end
          default: next_class = `HFCD_CLS_NONE;
        endcase
      end
      `HFCD_OP_SYSTEM: begin
        if (rd == 5'h00 && rs1 == 5'h00 && funct3 == 3'h0) begin
          if (funct12 == `HFCD_F12_WAIT_NO_TIMEOUT) begin
            next_class = `HFCD_CLS_WAIT_NO_TIMEOUT;
          end else if (funct12 == `HFCD_F12_WAIT_SHORT_TIMEOUT) begin
            next_class = `HFCD_CLS_WAIT_SHORT_TIMEOUT;
          end
        end
      end
      default: next_class = `HFCD_CLS_NONE;
    endcase
    next_illegal = (next_class == `HFCD_CLS_NONE);
    // Reserved rounding codes 5 and 6, or dynamic with a bad stored mode
    if (roundFieldUsed) begin
      if (funct3 == 3'h5 || funct3 == 3'h6) next_illegal = 1'b1;
      if (funct3 == `HFCD_ROUND_DYNAMIC && roundMode > 3'h4) next_illegal = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      decodeValid <= 1'b0;
      opClass <= `HFCD_CLS_NONE;
      opFunct7 <= 7'h00;
      opMinor <= 3'h0;
      opUnsigned <= 1'b0;
      opIllegal <= 1'b0;
      effRoundMode <= `HFCD_ROUND_RESET;
    end else begin
      decodeValid <= instrValid;
      if (instrValid) begin
        opClass <= next_class;
        opFunct7 <= funct7;
        opMinor <= funct3;
        opUnsigned <= instr[20];
        opIllegal <= next_illegal;
        effRoundMode <= (funct3 == `HFCD_ROUND_DYNAMIC) ? roundMode : funct3;
      end
    end
  end

  always @* begin
    next_rdata = 32'h00000000;
    next_error = 1'b0;
    case (csrAddr)
      `HFCD_ADDR_FP_FLAGS: next_rdata = {27'h0000000, fpFlags};
      `HFCD_ADDR_FP_ROUND: next_rdata = {29'h00000000, roundMode};
      `HFCD_ADDR_FP_COMBINED: next_rdata = {24'h000000, roundMode, fpFlags};
      `HFCD_ADDR_CYCLE: next_rdata = cycleCount[31:0];
      `HFCD_ADDR_TIME: next_rdata = timeCount[31:0];
      `HFCD_ADDR_RETIRED_LOW: next_rdata = retiredCount[31:0];
      `HFCD_ADDR_CYCLE_HIGH: begin
        next_rdata = cycleCount[63:32];
        next_error = is64Bit;
      end
      `HFCD_ADDR_TIME_HIGH: begin
        next_rdata = timeCount[63:32];
        next_error = is64Bit;
      end
      `HFCD_ADDR_RETIRED_HIGH: begin
        next_rdata = retiredCount[63:32];
        next_error = is64Bit;
      end
      default: next_error = 1'b1;
    endcase
    // Counters are read-only, so any write to them is refused
    if (csrWrite && csrAddr[11:10] == 2'h3) next_error = 1'b1;
    if (next_error) next_rdata = 32'h00000000;
  end

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      csrRdata <= 32'h00000000;
      csrError <= 1'b0;
      fpFlags <= `HFCD_FLAGS_RESET;
      roundMode <= `HFCD_ROUND_RESET;
    end else begin
      if (csrRead || csrWrite) begin
        csrRdata <= next_rdata;
        csrError <= next_error;
      end
      // A software write and a hardware flag event in one cycle merge
      if (csrWrite && !next_error && csrAddr == `HFCD_ADDR_FP_FLAGS) begin
        fpFlags <= csrWdata[4:0] | (fpFlagsSet ? fpFlagsIn : 5'h00);
      end else if (csrWrite && !next_error && csrAddr == `HFCD_ADDR_FP_COMBINED) begin
        fpFlags <= csrWdata[4:0] | (fpFlagsSet ? fpFlagsIn : 5'h00);
      end else if (fpFlagsSet) begin
        fpFlags <= fpFlags | fpFlagsIn;
      end
      if (csrWrite && !next_error && csrAddr == `HFCD_ADDR_FP_ROUND) begin
        roundMode <= csrWdata[2:0];
      end else if (csrWrite && !next_error && csrAddr == `HFCD_ADDR_FP_COMBINED) begin
        roundMode <= csrWdata[7:5];
      end
    end
  end
endmodule // hfcd_half_float_csr_decoder
`default_nettype wire

//--- hfcd_checker_assertions.sv
/* Port checker for the half-precision decoder.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module hfcd_checker (
  input wire clk_sys,
  input wire reset_n,
  input wire is64Bit,
  input wire instrValid,
  input wire [31:0] instr,
  input wire decodeValid,
  input wire [3:0] opClass,
  input wire [6:0] opFunct7,
  input wire [2:0] opMinor,
  input wire opUnsigned,
  input wire opIllegal,
  input wire [2:0] effRoundMode,
  input wire csrRead,
  input wire csrWrite,
  input wire [11:0] csrAddr,
  input wire [31:0] csrRdata,
  input wire csrError
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire [6:0] iF7 = instr[31:25];
  wire [2:0] iMinor = instr[14:12];
  wire iUns = instr[20];
  wire cvtLong = instr[6:0] == 7'h53 && iF7 == 7'h62 && instr[24:21] == 4'h1;
  dec_answer_a: assert property (instrValid |=> decodeValid)
    else $error("decode answer missing");
  dec_single_a: assert property (!instrValid |=> !decodeValid)
    else $error("decode answer without request");
  fields_copy_a: assert property (instrValid |=> opFunct7 == $past(iF7) &&
    opMinor == $past(iMinor) && opUnsigned == $past(iUns)) else $error("field copy wrong");
  static_rm_a: assert property (instrValid && iMinor != 3'h7 |=>
    effRoundMode == $past(iMinor)) else $error("static rounding mode wrong");
  none_illegal_a: assert property (decodeValid && opClass == 4'h0 |-> opIllegal)
    else $error("unknown class not illegal");
  long_base32_a: assert property (instrValid && !is64Bit && cvtLong |=>
    opIllegal && opClass == 4'h0) else $error("long conversion accepted on 32-bit base");
  long_base64_a: assert property (instrValid && is64Bit && cvtLong && iMinor == 3'h0 |=>
    !opIllegal && opClass == 4'hA) else $error("long conversion refused on 64-bit base");
  wait_nto_a: assert property (instrValid && instr == 32'h00D00073 |=>
    opClass == 4'hB && !opIllegal) else $error("wait without timeout not decoded");
  ro_write_a: assert property (csrWrite && csrAddr[11:8] == 4'hC |=> csrError)
    else $error("counter write not refused");
  high_hidden_a: assert property (csrRead && is64Bit && csrAddr[11:4] == 8'hC8 |=>
    csrError && csrRdata == 32'h0) else $error("upper half visible on 64-bit base");
  gap_unmapped_a: assert property (csrRead && csrAddr > 12'h003 && csrAddr < 12'hC00 |=>
    csrError) else $error("unallocated register answered");
  cover property (decodeValid && opClass == 4'hA);
  cover property (csrWrite && csrAddr == 12'h003);
  cover property (instrValid && cvtLong && is64Bit);
endmodule // hfcd_checker
bind hfcd_half_float_csr_decoder hfcd_checker u_chk (.clk_sys, .reset_n, .is64Bit, .instrValid,
  .instr, .decodeValid, .opClass, .opFunct7, .opMinor, .opUnsigned, .opIllegal, .effRoundMode,
  .csrRead, .csrWrite, .csrAddr, .csrRdata, .csrError);
`default_nettype wire

//--- hfcd_hart_model.sv
/* Hart-side model: retire pulses and a divided timer tick.
   Assumes the decoder's outputs and the same clock. */
`timescale 1ns/1ps
`default_nettype none
module hfcd_hart_model #(parameter [7:0] TICK_DIV = 8'h04) (
  input wire clk_sys,
  input wire reset_n,
  input wire decodeValid,
  input wire opIllegal,
  output reg retirePulse,
  output reg timeTick
);
  reg [7:0] tickCnt;
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      tickCnt <= 8'h00;
      timeTick <= 1'h0;
      retirePulse <= 1'h0;
    end else begin
      // Only legal decodes retire, one cycle after the answer
      retirePulse <= decodeValid & ~opIllegal;
      tickCnt <= (tickCnt == TICK_DIV - 8'h01) ? 8'h00 : tickCnt + 8'h01;
      timeTick <= (tickCnt == TICK_DIV - 8'h01);
    end
  end
endmodule // hfcd_hart_model
`default_nettype wire

//--- hfcd_tb.sv
/* Self-checking bench for the decoder and its register map.
   Assumes the hart model supplies retire and tick pulses, tick every 4 cycles. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  reg clk_sys = 1'h0;
  reg reset_n = 1'h0;
  reg is64Bit = 1'h0;
  reg instrValid = 1'h0;
  reg [31:0] instr = 32'h0;
  reg csrRead = 1'h0;
  reg csrWrite = 1'h0;
  reg [11:0] csrAddr = 12'h000;
  reg [31:0] csrWdata = 32'h0;
  reg fpFlagsSet = 1'h0;
  reg [4:0] fpFlagsIn = 5'h00;
  wire decodeValid, opUnsigned, opIllegal, csrError, retirePulse, timeTick;
  wire [3:0] opClass;
  wire [6:0] opFunct7;
  wire [2:0] opMinor, effRoundMode;
  wire [31:0] csrRdata;
  integer error_cnt = 0;
  integer n_compared = 0;
  integer k;
  reg [31:0] q0;
  always #2.5 clk_sys = ~clk_sys;
  hfcd_half_float_csr_decoder u_dut (.clk_sys, .reset_n, .is64Bit, .instrValid, .instr,
    .decodeValid, .opClass, .opFunct7, .opMinor, .opUnsigned, .opIllegal, .effRoundMode,
    .csrRead, .csrWrite, .csrAddr, .csrWdata, .csrRdata, .csrError, .fpFlagsSet, .fpFlagsIn,
    .retirePulse, .timeTick);
  hfcd_hart_model u_hart (.clk_sys, .reset_n, .decodeValid, .opIllegal, .retirePulse, .timeTick);
  task chk(input string name, input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // Read accompanies every write, so a write returns the prior value
  task cchk(input m, input w, input [11:0] a, input [31:0] d, input [31:0] eq, input ee);
    begin
      @(posedge clk_sys);
      is64Bit <= m;
      csrRead <= 1'h1;
      csrWrite <= w;
      csrAddr <= a;
      csrWdata <= d;
      @(posedge clk_sys);
      csrRead <= 1'h0;
      csrWrite <= 1'h0;
      #1;
      q0 = csrRdata;
      chk("csrRdata", csrRdata, eq);
      chk("csrError", {31'h0, csrError}, {31'h0, ee});
    end
  endtask
  // Snapshot of a running count; only its advance over time is checked
  task cget(input [11:0] a);
    begin
      @(posedge clk_sys);
      is64Bit <= 1'h0;
      csrRead <= 1'h1;
      csrAddr <= a;
      @(posedge clk_sys);
      csrRead <= 1'h0;
      #1;
      q0 = csrRdata;
      chk("csrError", {31'h0, csrError}, 32'h0);
    end
  endtask
  task dchk(input [31:0] i, input m, input [3:0] c, input ill);
    begin
      @(posedge clk_sys);
      is64Bit <= m;
      instrValid <= 1'h1;
      instr <= i;
      @(posedge clk_sys);
      instrValid <= 1'h0;
      #1;
      chk("opClass", {28'h0, opClass}, {28'h0, c});
      chk("opIllegal", {31'h0, opIllegal}, {31'h0, ill});
    end
  endtask
  initial begin
    #20000;
    error_cnt = error_cnt + 1;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'h1;
    cchk(0, 0, 12'h001, 0, 0, 0);
    cchk(0, 1, 12'h003, 32'hFF, 0, 0);
    cchk(0, 0, 12'h001, 0, 32'h1F, 0);
    cchk(0, 1, 12'h002, 32'h3, 32'h7, 0);
    cchk(0, 1, 12'h001, 32'h5, 32'h1F, 0);
    cchk(0, 0, 12'h003, 0, 32'h65, 0);
    @(posedge clk_sys);
    fpFlagsSet <= 1'h1;
    fpFlagsIn <= 5'h08;
    @(posedge clk_sys);
    fpFlagsSet <= 1'h0;
    cchk(0, 0, 12'h001, 0, 32'h0D, 0);
    cchk(0, 0, 12'h004, 0, 0, 1);
    cchk(0, 0, 12'h7C0, 0, 0, 1);
    $display("test float registers done");
    for (k = 0; k < 2; k = k + 1) begin
      cget(12'hC00 + k[11:0]);
      repeat (6) @(posedge clk_sys);
      cchk(0, 0, 12'hC00 + k[11:0], 0, q0 + ((k == 0) ? 8 : 2), 0);
    end
    cchk(0, 0, 12'hC02, 0, 0, 0);
    for (k = 0; k < 3; k = k + 1)
      dchk(32'h04000053, 0, 4'h4, 0);
    repeat (4) @(posedge clk_sys);
    cchk(0, 0, 12'hC02, 0, 32'h3, 0);
    cchk(0, 1, 12'hC00, 32'h5, 0, 1);
    for (k = 0; k < 6; k = k + 1)
      cchk(k > 2, 0, 12'hC80 + k[11:0] % 12'h3, 0, 0, k > 2);
    $display("test counters done");
    dchk(32'h00009107, 0, 4'h1, 0);
    dchk(32'h00001027, 0, 4'h2, 0);
    dchk(32'h04000043, 0, 4'h3, 0);
    dchk(32'h0000004F, 0, 4'h0, 1);
    dchk(32'h24000053, 0, 4'h5, 0);
    dchk(32'h2C001053, 0, 4'h6, 0);
    dchk(32'hA4002053, 0, 4'h7, 0);
    dchk(32'hE4001053, 0, 4'h8, 0);
    dchk(32'hF4000053, 0, 4'h9, 0);
    dchk(32'hC4000053, 0, 4'hA, 0);
    dchk(32'h04007053, 0, 4'h4, 0);
    chk("effRoundMode", {29'h0, effRoundMode}, 32'h3);
    dchk(32'h5C000053, 0, 4'h4, 0);
    dchk(32'h40200053, 0, 4'hA, 0);
    dchk(32'h44100053, 0, 4'hA, 0);
    dchk(32'hE4000053, 0, 4'h9, 0);
    dchk(32'h04005053, 0, 4'h4, 1);
    cchk(0, 1, 12'h002, 32'h7, 32'h3, 0);
    dchk(32'h04007053, 0, 4'h4, 1);
    dchk(32'hC4200053, 0, 4'h0, 1);
    dchk(32'hD4200053, 0, 4'h0, 1);
    dchk(32'hD4200053, 1, 4'hA, 0);
    dchk(32'hC4300053, 1, 4'hA, 0);
    chk("opUnsigned", {31'h0, opUnsigned}, 32'h1);
    dchk(32'h00D00073, 0, 4'hB, 0);
    dchk(32'h01D00073, 0, 4'hC, 0);
    dchk(32'h01D00173, 0, 4'h0, 1);
    $display("test decode done");
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
